// File: design/chan_power_pkg.sv
// Purpose: shared constants and carriers for the channel, gain-control and power registers
// Assumes: eight-bit registers reached over a byte-wide control port
// Notes:   offsets are register addresses on the control port
package chan_power_pkg;

	// register addresses
	localparam logic [7:0] GAIN_CFG_ADDR   = 8'h70;
	localparam logic [7:0] IN_EN_ADDR      = 8'h73;
	localparam logic [7:0] SLOT_EN_ADDR    = 8'h74;
	localparam logic [7:0] POWER_CONFIGURATION_ADDR    = 8'h75;

	// reset values
	localparam logic [3:0] LEVEL_RST       = 4'he;
	localparam logic [3:0] CEIL_RST        = 4'h7;
	localparam logic [7:0] IN_EN_RST       = 8'hfc;
	localparam logic [7:0] SLOT_EN_RST     = 8'h00;
	localparam logic [7:0] PWR_RST         = 8'h00;

	// field positions in the power configuration register
	localparam int         MIC_BIAS_BIT    = 7;
	localparam int         CONV_BIT        = 6;
	localparam int         PLL_BIT         = 5;
	localparam int         DYN_BIT         = 4;
	localparam int         COUNT_HI        = 3;
	localparam int         COUNT_LO        = 2;
	localparam int         RSVD_RW_BIT     = 1;
	localparam logic [7:0] PWR_WR_MASK     = 8'hfe;

	// gain-control scaling, in dB
	localparam int         LEVEL_TOP_DB    = -6;
	localparam int         LEVEL_STEP_DB   = 2;
	localparam int         CEIL_BASE_DB    = 3;
	localparam int         CEIL_STEP_DB    = 3;
	localparam logic [3:0] CEIL_MAX_CODE   = 4'hd;

	// decoded power controls
	typedef struct packed {
		logic       mic_bias_power;
		logic       pll_power;
		logic       dynamic_chan_power_on;
		logic [7:0] chan_power;
		logic [7:0] dynamic_chan_mask;
	} power_ctl_t;

	// gain-control settings in dB
	typedef struct packed {
		logic signed [7:0] target_db;
		logic        [7:0] ceiling_db;
		logic              ceiling_reserved;
	} gain_ctl_t;

endpackage

// File: design/chan_power_regs.sv
// Purpose: register slice for gain control, channel enables and power configuration
// Assumes: control port decoded to a byte address with write and read strobes
// Notes:   read data is registered one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none

module chan_power_regs
	import chan_power_pkg::*;
(
	// clock, reset, enable
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       ce,
	// control port
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output var  logic [7:0] rdata,
	output var  logic       rd_hit,
	// decoded controls
	output var  power_ctl_t power_ctl,
	output var  gain_ctl_t  gain_ctl,
	output var  logic [7:0] slot_drive_en,
	output var  logic [3:0] analog_conv_on,
	output var  logic [3:0] mic_path_on
);

	logic [7:0] gain_reg, gain_next;
	logic [7:0] in_en_reg, in_en_next;
	logic [7:0] slot_reg, slot_next;
	logic [7:0] pwr_reg, pwr_next;

	function automatic logic [7:0] count_mask(input logic [1:0] sel);
		case (sel)
			2'h0: count_mask = 8'hc0;
			2'h1: count_mask = 8'hf0;
			2'h2: count_mask = 8'hfc;
			default: count_mask = 8'hff;
		endcase
	endfunction

	// address decode
	wire hit_gain  = (addr == GAIN_CFG_ADDR);
	wire hit_in    = (addr == IN_EN_ADDR);
	wire hit_slot  = (addr == SLOT_EN_ADDR);
	wire hit_pwr   = (addr == POWER_CONFIGURATION_ADDR);
	wire any_hit   = hit_gain | hit_in | hit_slot | hit_pwr;

	assign gain_next  = (wr && hit_gain) ? wdata : gain_reg;
	assign in_en_next = (wr && hit_in) ? wdata : in_en_reg;
	assign slot_next  = (wr && hit_slot) ? wdata : slot_reg;
	// bit 0 never stores; reserved bit 1 stored as written
	assign pwr_next   = (wr && hit_pwr) ? (wdata & PWR_WR_MASK) : pwr_reg;

	// read mux, unmapped reads return zero
	wire [7:0] rd_mux = hit_gain ? gain_reg :
		hit_in ? in_en_reg :
		hit_slot ? slot_reg :
		hit_pwr ? pwr_reg : 8'h00;

	// converter power reaches enabled channels only
	wire [7:0] conv_up   = pwr_reg[CONV_BIT] ? in_en_reg : 8'h00;
	wire [7:0] dyn_mask  = count_mask(pwr_reg[COUNT_HI:COUNT_LO]);
	// channel one held up when dynamic mode and converters on
	wire [7:0] chan_pwr  = (pwr_reg[DYN_BIT] && pwr_reg[CONV_BIT]) ?
		(conv_up | 8'h80) : conv_up;

	// linear dB mapping across all codes
	wire signed [7:0] tgt_db = 8'(LEVEL_TOP_DB) -
		8'(LEVEL_STEP_DB) * $signed({4'h0, gain_reg[7:4]});
	wire [7:0] ceil_db = 8'(CEIL_BASE_DB) + 8'(CEIL_STEP_DB) * {4'h0, gain_reg[3:0]};
	// flag reserved ceiling codes, device behaviour there undefined
	wire ceil_rsvd = (gain_reg[3:0] > CEIL_MAX_CODE);

	// register state, frozen while ce is low
	always_ff @(posedge clk) begin
		if (!rstn) begin
			gain_reg  <= {LEVEL_RST, CEIL_RST};
			in_en_reg <= IN_EN_RST;
			slot_reg  <= SLOT_EN_RST;
			pwr_reg   <= PWR_RST;
		end else if (ce) begin
			gain_reg  <= gain_next;
			in_en_reg <= in_en_next;
			slot_reg  <= slot_next;
			pwr_reg   <= pwr_next;
		end
	end

	// registered outputs, one cycle behind the register state
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rdata          <= 8'h00;
			rd_hit         <= 1'b0;
			power_ctl      <= '0;
			gain_ctl       <= '0;
			slot_drive_en  <= 8'h00;
			analog_conv_on <= 4'h0;
			mic_path_on    <= 4'h0;
		end else if (ce) begin
			rdata          <= rd ? rd_mux : 8'h00;
			rd_hit         <= rd & any_hit;
			power_ctl      <= '{pwr_reg[MIC_BIAS_BIT], pwr_reg[PLL_BIT],
				pwr_reg[DYN_BIT], chan_pwr, dyn_mask};
			gain_ctl       <= '{tgt_db, ceil_db, ceil_rsvd};
			slot_drive_en  <= slot_reg;
			analog_conv_on <= chan_pwr[7:4];
			mic_path_on    <= chan_pwr[3:0];
		end
	end

	// write, read and output checks look one edge after their cause, since state and outputs are registered
	// reset value of level
	level_reset_a: assert property (@(posedge clk)
		$rose(rstn) |-> gain_reg[7:4] == LEVEL_RST)
		else $error("level reset wrong");
	level_write_a: assert property (@(posedge clk) disable iff (!rstn)
		(ce && wr && hit_gain) |=> gain_reg[7:4] == $past(wdata[7:4]))
		else $error("level write lost");
	ceil_reset_a: assert property (@(posedge clk)
		$rose(rstn) |-> gain_reg[3:0] == CEIL_RST)
		else $error("ceiling reset wrong");
	ceil_write_a: assert property (@(posedge clk) disable iff (!rstn)
		(ce && wr && hit_gain) |=> gain_reg[3:0] == $past(wdata[3:0]))
		else $error("ceiling write lost");
	ceil_flag_a: assert property (@(posedge clk) disable iff (!rstn)
		ce |=> gain_ctl.ceiling_reserved == ($past(gain_reg[3:0]) > 4'hd))
		else $error("reserved ceiling flag wrong");
	in_reset_a: assert property (@(posedge clk)
		$rose(rstn) |-> in_en_reg == 8'hfc)
		else $error("channel enable reset wrong");
	in_write_a: assert property (@(posedge clk) disable iff (!rstn)
		(ce && wr && hit_in) |=> in_en_reg == $past(wdata))
		else $error("channel enable write lost");
	path_split_a: assert property (@(posedge clk) disable iff (!rstn)
		{analog_conv_on, mic_path_on} == power_ctl.chan_power)
		else $error("channel halves split wrong");
	slot_write_a: assert property (@(posedge clk) disable iff (!rstn)
		(ce && wr && hit_slot) |=> slot_reg == $past(wdata))
		else $error("slot enable write lost");
	slot_follow_a: assert property (@(posedge clk) disable iff (!rstn)
		ce |=> slot_drive_en == $past(slot_reg))
		else $error("slot drive mismatch");
	pwr_bit0_a: assert property (@(posedge clk) disable iff (!rstn)
		pwr_reg[0] == 1'b0)
		else $error("power bit 0 set");
	pwr_write_a: assert property (@(posedge clk) disable iff (!rstn)
		(ce && wr && hit_pwr) |=> pwr_reg[7:1] == $past(wdata[7:1]))
		else $error("power write lost");
	pwr_read_a: assert property (@(posedge clk) disable iff (!rstn)
		(ce && rd && hit_pwr) |=> rdata == $past(pwr_reg))
		else $error("power read wrong");
	conv_off_a: assert property (@(posedge clk) disable iff (!rstn)
		(ce && !pwr_reg[CONV_BIT]) |=> power_ctl.chan_power == 8'h00)
		else $error("channel powered with converter off");
	conv_on_a: assert property (@(posedge clk) disable iff (!rstn)
		(ce && pwr_reg[CONV_BIT] && !pwr_reg[DYN_BIT]) |=>
			power_ctl.chan_power == $past(in_en_reg))
		else $error("enabled channels not powered");
	// bias and pll follow their bits
	bias_pll_a: assert property (@(posedge clk) disable iff (!rstn)
		ce |=> {power_ctl.mic_bias_power, power_ctl.pll_power} ==
			{$past(pwr_reg[MIC_BIAS_BIT]), $past(pwr_reg[PLL_BIT])})
		else $error("bias or pll control wrong");
	dyn_flag_a: assert property (@(posedge clk) disable iff (!rstn)
		ce |=> power_ctl.dynamic_chan_power_on == $past(pwr_reg[DYN_BIT]))
		else $error("dynamic enable wrong");
	// channel one kept up in dynamic mode with converters on
	dyn_ch1_a: assert property (@(posedge clk) disable iff (!rstn)
		(ce && pwr_reg[DYN_BIT] && pwr_reg[CONV_BIT]) |=> power_ctl.chan_power[7])
		else $error("channel one dropped");
	dyn_count_a: assert property (@(posedge clk) disable iff (!rstn)
		(ce && pwr_reg[COUNT_HI:COUNT_LO] == 2'h3) |=> power_ctl.dynamic_chan_mask == 8'hff)
		else $error("count mask wrong");
	// code 0 selects channels one, two
	dyn_pair_a: assert property (@(posedge clk) disable iff (!rstn)
		(ce && pwr_reg[COUNT_HI:COUNT_LO] == 2'h0) |=> power_ctl.dynamic_chan_mask == 8'hc0)
		else $error("pair mask wrong");
	level_db_a: assert property (@(posedge clk) disable iff (!rstn)
		ce |=> gain_ctl.target_db == 8'(-6 - 2 * int'($past(gain_reg[7:4]))))
		else $error("target dB wrong");
	ceil_db_a: assert property (@(posedge clk) disable iff (!rstn)
		ce |=> gain_ctl.ceiling_db == 8'(3 + 3 * int'($past(gain_reg[3:0]))))
		else $error("ceiling dB wrong");

endmodule

`default_nettype wire

// File: dv/host_model.sv
// Purpose: host on the register control port
// Assumes: one strobe per call, driven just after a rising edge
// Notes:   read data is taken one edge after the strobe edge
`timescale 1ns/1ps
`default_nettype none
module host_model
	import chan_power_pkg::*;
(
	// clock
	input  wire logic       clk,
	// control port
	output var  logic [7:0] addr,
	output var  logic [7:0] wdata,
	output var  logic       wr,
	output var  logic       rd,
	input  wire logic [7:0] rdata,
	input  wire logic       rd_hit
);
	// idle port at time zero
	initial begin
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == GAIN_CFG_ADDR && v[3:0] > CEIL_MAX_CODE) v[3:0] = CEIL_MAX_CODE;
		if (a == POWER_CONFIGURATION_ADDR) v[1:0] = 2'h0;
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic h);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
		h = rd_hit;
	endtask
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Purpose: random and corner checks of the register slice
// Assumes: ce held high except in one freeze check
// Notes:   host never writes reserved codes, so those stay unseen
`timescale 1ns/1ps
`default_nettype none
module testbench
	import chan_power_pkg::*;
;
	logic       clk, rstn, ce, wr, rd, rd_hit, hv;
	logic [7:0] addr, wdata, rdata, slot_drive_en, rv, gv, iv, sv, pv;
	logic [3:0] analog_conv_on, mic_path_on;
	logic [31:0] seed;
	power_ctl_t pc;
	gain_ctl_t  gc;
	int         n_fail, n_compared, cyc;
	always #25 clk = ~clk;
	chan_power_regs dut (.clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .rd_hit(rd_hit), .power_ctl(pc), .gain_ctl(gc),
		.slot_drive_en(slot_drive_en), .analog_conv_on(analog_conv_on),
		.mic_path_on(mic_path_on));
	host_model h (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .rd_hit(rd_hit));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// expected dB values and participation mask, worked out from the rules
	function automatic logic [7:0] exp_target(input logic [3:0] c);
		return 8'(LEVEL_TOP_DB - LEVEL_STEP_DB * int'(c));
	endfunction
	function automatic logic [7:0] exp_ceiling(input logic [3:0] c);
		return 8'(CEIL_BASE_DB + CEIL_STEP_DB * int'(c));
	endfunction
	function automatic logic [7:0] exp_mask(input logic [1:0] s);
		return 8'hff << (6 - 2 * int'(s));
	endfunction
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic eh);
		h.rd_reg(a, rv, hv);
		chk("rdata", e, rv);
		chk("rd_hit", {7'h0, eh}, {7'h0, hv});
	endtask
	task automatic conclude;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// hang guard, well above the run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			conclude;
		end
	end
	initial begin
		clk = 0; rstn = 0; ce = 1; n_fail = 0; n_compared = 0; cyc = 0;
		seed = 32'd70396;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		rchk(8'h70, 8'he7, 1'b1);
		rchk(8'h73, 8'hfc, 1'b1);
		rchk(8'h74, 8'h00, 1'b1);
		rchk(8'h75, 8'h00, 1'b1);
		rchk(8'h72, 8'h00, 1'b0);
		for (int i = 0; i < 40; i++) begin
			seed = lfsr(seed);
			{gv, iv, sv, pv} = seed;
			// first sixteen walk every level code and ceiling codes 0 to 13
			if (i < 16) gv = {i[3:0], 4'(i % 14)};
			if (gv[3:0] > 4'hd) gv[3:0] = 4'hd;
			pv[1:0] = 2'h0;
			if (pv[4]) iv[7] = 1'b1;
			h.wr_reg(8'h70, gv);
			h.wr_reg(8'h73, iv);
			h.wr_reg(8'h74, sv);
			h.wr_reg(8'h75, pv);
			rchk(8'h70, gv, 1'b1);
			rchk(8'h73, iv, 1'b1);
			rchk(8'h74, sv, 1'b1);
			rchk(8'h75, pv, 1'b1);
			chk("slot", sv, slot_drive_en);
			chk("target", exp_target(gv[7:4]), gc.target_db);
			chk("ceiling", exp_ceiling(gv[3:0]), gc.ceiling_db);
			chk("resv", 8'h0, {7'h0, gc.ceiling_reserved});
			chk("chan", pv[6] ? iv : 8'h00, pc.chan_power);
			chk("analog", {4'h0, pv[6] ? iv[7:4] : 4'h0}, {4'h0, analog_conv_on});
			chk("mic", {4'h0, pv[6] ? iv[3:0] : 4'h0}, {4'h0, mic_path_on});
			chk("ctl", {5'h0, pv[7], pv[5], pv[4]},
				{5'h0, pc.mic_bias_power, pc.pll_power, pc.dynamic_chan_power_on});
			if (pv[4]) chk("mask", exp_mask(pv[3:2]), pc.dynamic_chan_mask);
		end
		// mid-run reset brings every register and control back
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rchk(GAIN_CFG_ADDR, {LEVEL_RST, CEIL_RST}, 1'b1);
		rchk(IN_EN_ADDR, IN_EN_RST, 1'b1);
		rchk(SLOT_EN_ADDR, SLOT_EN_RST, 1'b1);
		rchk(POWER_CONFIGURATION_ADDR, PWR_RST, 1'b1);
		chk("slot", SLOT_EN_RST, slot_drive_en);
		chk("chan", 8'h00, pc.chan_power);
		// ce low freezes the registers, so this write must be lost
		ce <= 1'b0;
		h.wr_reg(SLOT_EN_ADDR, 8'h5a);
		ce <= 1'b1;
		rchk(SLOT_EN_ADDR, SLOT_EN_RST, 1'b1);
		conclude;
	end
endmodule
`default_nettype wire
